/* File: src/aas_pkg.sv */
/*
 * Shared constants, carriers and state types of the converter sequencer control.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package aas_pkg;
    // timing
    localparam int SYS_CLK_MHZ = 100;
    localparam int CONV_CLK_MHZ = 25;
    localparam int CONV_TIME_NS = 80;
    localparam int CONV_DIV_BASE = SYS_CLK_MHZ / CONV_CLK_MHZ;
    localparam int CONV_TICKS = (CONV_TIME_NS * CONV_CLK_MHZ + 999) / 1000;
    localparam int ACQ_UNIT_CYCLES = 2;
    // transfer function
    localparam int FULL_SCALE_MV = 3000;
    localparam int CODE_SPAN = 4096;
    localparam logic [11:0] CODE_MAX = 12'hFFF;
    // slots
    localparam int NUM_SLOTS = 16;
    localparam logic [3:0] SEQ2_FIRST_SLOT = 4'h8;
    // register offsets (byte addresses) and wbAdr[7:6] region codes
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_START = 8'h04;
    localparam logic [7:0] REG_MAXCONV = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;
    localparam logic [1:0] REGION_SLOT = 2'h1;
    localparam logic [1:0] REGION_RESULT = 2'h2;
    // reset values
    localparam logic [6:0] MAXCONV_RESET = 7'h00;
    localparam logic [1:0] INT_RESET = 2'h0;

    typedef struct packed {
        logic [3:0] acqPrescale;
        logic [3:0] convPrescale;
        logic startStop;
        logic everyOther;
        logic cascade;
        logic convClockEnable;
    } aas_ctrl_s;

    localparam aas_ctrl_s CTRL_RESET = 12'h000;

    typedef struct packed {
        logic valid;
        logic [11:0] code;
    } aas_result_s;

    typedef enum logic [1:0] {CT_IDLE, CT_ACQ, CT_CONV} aas_conv_e;
    typedef enum logic {ARB_IDLE, ARB_CONVERT} aas_arb_e;
endpackage

/* File: src/aas_conv_timer.sv */
/*
 * Conversion timer: sample-and-hold window, converter clock divider and
 * code computation for one conversion at a time.
 * Assumes the level input is already synchronised to the system clock.
 */
`timescale 1ns/100ps
module aas_conv_timer
    import aas_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic [3:0] convPrescale,
    input wire logic [3:0] acqPrescale,
    input wire logic signed [15:0] levelMv,
    output logic sampleHold,
    output logic busy,
    output aas_result_s result
);
    aas_conv_e state_q;
    logic [7:0] cnt_q;
    logic [7:0] div_q;
    logic signed [15:0] held_q;
    logic [7:0] divLimit;
    logic [7:0] acqLimit;
    logic tick;

    assign divLimit = 8'((32'(convPrescale) + 1) * CONV_DIV_BASE - 1);
    assign acqLimit = 8'((32'(acqPrescale) + 1) * ACQ_UNIT_CYCLES - 1);
    assign tick = (div_q == divLimit);
    assign busy = (state_q != CT_IDLE);

    function automatic logic [11:0] toCode(input logic signed [15:0] mv);
        logic [27:0] scaled;
        scaled = 28'(unsigned'(mv)) * 28'(CODE_SPAN);
        // [R1] clamp and truncate
        if (mv <= 0)
            return 12'h000;
        else if (mv >= FULL_SCALE_MV)
            return CODE_MAX;
        return 12'(scaled / 28'(FULL_SCALE_MV));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // [R11] separate acquisition count
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_q <= CT_IDLE;
            cnt_q <= 8'h00;
            div_q <= 8'h00;
            held_q <= 16'sh0000;
            sampleHold <= 1'b0;
            result <= '0;
        end
        else
        begin
            result.valid <= 1'b0;
            case (state_q)
                CT_IDLE:
                    if (start)
                    begin
                        state_q <= CT_ACQ;
                        cnt_q <= 8'h00;
                        sampleHold <= 1'b1;
                    end
                CT_ACQ:
                    if (cnt_q == acqLimit)
                    begin
                        state_q <= CT_CONV;
                        held_q <= levelMv;
                        sampleHold <= 1'b0;
                        cnt_q <= 8'h00;
                        div_q <= 8'h00;
                    end
                    else
                        cnt_q <= cnt_q + 8'h01;
                // [R17] two converter clocks
                CT_CONV:
                begin
                    div_q <= tick ? 8'h00 : div_q + 8'h01;
                    if (tick)
                    begin
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q == 8'(CONV_TICKS - 1))
                        begin
                            state_q <= CT_IDLE;
                            result.valid <= 1'b1;
                            result.code <= toCode(held_q);
                        end
                    end
                end
                default:
                    state_q <= CT_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_conv_time_min: assert property (@(posedge clock) disable iff (reset) // [R17]
        $rose(state_q == CT_CONV) && convPrescale == 4'h0 |-> ##8 result.valid)
        else $error("conversion did not end after 80 ns");
    a_code_full_scale: assert property (@(posedge clock) disable iff (reset) // [R1]
        state_q == CT_CONV && held_q >= FULL_SCALE_MV && result.valid == 1'b0
        && tick && cnt_q == 8'(CONV_TICKS - 1) |=> result.code == CODE_MAX)
        else $error("full scale input did not give the top code");
endmodule

/* File: src/aas_top.sv */
/*
 * Converter autosequencer control: two 8-slot or one 16-slot sequencer sharing
 * one converter, result registers, triggers, interrupt and power control.
 * Assumes trigger pins, halt and level input are asynchronous, and that an
 * external analog mux follows muxChannel and delivers the level in millivolts.
 */
// Decided for this implementation: the register addresses and the Wishbone register port.
// Function
// [R1] codes: 0 at or below 0 V, 4095 at 3 V, else 4096*v/3 truncated.
// [R2] up to 16 conversions per session, each slot picks any channel.
// [R3] two independent 8-slot sequencers or one cascaded 16-slot one.
// [R4] both sequencers share one converter; conversions are serialised.
// [R5] dual mode: each sequencer uses its own eight channels only.
// [R6] each result lands in the result register of its slot.
// [R7] starts come from software, a pwm trigger or the external pin.
// [R8] interrupt on every end of sequence or every second one.
// [R9] start/stop mode: each trigger advances one slot.
// [R10] dual mode: first pwm trigger to sequencer 1, second to sequencer 2.
// [R11] acquisition window has its own prescaler.
// [R12] registers on the system clock, conversion timing by divider enables.
// [R13] enable low after reset; registers clocked, core off during reset.
// [R14] register clock stops after reset until enable; enable wakes core.
// [R15] software waits milliseconds after enabling before converting; the bench waits only 200 clock cycles (2 us).
// [R16] halt powers the core down and keeps registers.
// [R17] one conversion takes 80 ns at a 25 MHz converter clock.
// [R18] several slots may name the same channel.
// [R19] slot pointer starts at first slot, advances, flags end after last.
`timescale 1ns/100ps
module aas_top
    import aas_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatWr,
    output logic [31:0] wbDatRd,
    output logic wbAck,
    input wire logic firstPwmConvTrigger,
    input wire logic secondPwmConvTrigger,
    input wire logic externalTriggerPin,
    input wire logic haltMode,
    input wire logic signed [15:0] analogLevelMv,
    output logic [3:0] muxChannel,
    output logic sampleHold,
    output logic analogCoreEnable,
    output logic regClockEnable,
    output logic irq
);
    aas_ctrl_s ctrl_q;
    logic [6:0] maxConv_q;
    logic [1:0] intStat_q;
    logic [1:0] intMask_q;
    logic [3:0] slotSel_q [NUM_SLOTS];
    logic [11:0] resultMem_q [NUM_SLOTS];
    logic [3:0] syncA_q;
    logic [3:0] syncB_q;
    logic [2:0] trigPrev_q;
    logic signed [15:0] levelA_q;
    logic signed [15:0] levelB_q;
    logic [1:0] seqActive_q;
    logic [3:0] ptr_q [2];
    logic [1:0] evenEos_q;
    aas_arb_e arb_q;
    logic owner_q;
    logic [3:0] slot_q;
    logic startConv_q;
    logic [31:0] wmask;
    logic busReq;
    logic wbWrite;
    logic regRun;
    logic coreOn;
    logic [2:0] trigRise;
    logic [1:0] swStart;
    logic [1:0] trigReq;
    logic [3:0] firstSlot [2];
    logic [3:0] lastSlot [2];
    logic [1:0] eosEvent;
    logic [1:0] intSet;
    logic grant;
    logic convBusy;
    aas_result_s convResult;
    logic [31:0] rdData;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            syncA_q <= 4'h0;
            syncB_q <= 4'h0;
            trigPrev_q <= 3'h0;
            levelA_q <= 16'sh0000;
            levelB_q <= 16'sh0000;
        end
        else
        begin
            syncA_q <= {haltMode, externalTriggerPin, secondPwmConvTrigger,
                firstPwmConvTrigger};
            syncB_q <= syncA_q;
            trigPrev_q <= syncB_q[2:0];
            // level is only sampled at the end of acquisition, so skew is harmless
            levelA_q <= analogLevelMv;
            levelB_q <= levelA_q;
        end
    end

    assign trigRise = syncB_q[2:0] & ~trigPrev_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode; a write lands on the edge at which the master samples ack high
    assign busReq = wbCyc && wbStb && !wbAck;
    assign wbWrite = wbCyc && wbStb && wbAck && wbWe;
    assign wmask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
    // [R14] non-control writes need the register clock
    assign regRun = ctrl_q.convClockEnable;
    // [R16] halt powers the core down
    assign coreOn = ctrl_q.convClockEnable && !syncB_q[3];

    // [R7] three start sources
    assign swStart = (wbWrite && regRun && wbAdr == REG_START && wbSel[0])
        ? wbDatWr[1:0] : 2'h0;
    // [R10] pwm routing in dual mode
    assign trigReq[0] = regRun && (swStart[0] || trigRise[0] || trigRise[2]
        || (ctrl_q.cascade && trigRise[1]));
    assign trigReq[1] = regRun && !ctrl_q.cascade && (swStart[1] || trigRise[1]);

    // [R3] slot ranges per mode
    always_comb
    begin
        firstSlot[0] = 4'h0;
        firstSlot[1] = SEQ2_FIRST_SLOT;
        lastSlot[0] = ctrl_q.cascade ? maxConv_q[3:0] : {1'b0, maxConv_q[2:0]};
        lastSlot[1] = {1'b1, maxConv_q[6:4]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and configuration registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            // [R13] enable low, core off
            ctrl_q <= CTRL_RESET;
            maxConv_q <= MAXCONV_RESET;
            intMask_q <= INT_RESET;
        end
        else if (wbWrite)
        begin
            if (wbAdr == REG_CTRL)
                ctrl_q <= aas_ctrl_s'((wbDatWr[11:0] & wmask[11:0]) | (ctrl_q & ~wmask[11:0]));
            else if (regRun && wbAdr == REG_MAXCONV && wbSel[0])
                maxConv_q <= wbDatWr[6:0];
            else if (regRun && wbAdr == REG_INT_MASK && wbSel[0])
                intMask_q <= wbDatWr[1:0];
        end
    end

    // [R2] [R18] any channel, repeats allowed
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
                slotSel_q[i] <= 4'h0;
        end
        else if (wbWrite && regRun && wbAdr[7:6] == REGION_SLOT && wbSel[0])
            slotSel_q[wbAdr[5:2]] <= wbDatWr[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // arbiter; sequencer 1 wins a tie
    assign grant = !seqActive_q[0];

    // [R4] one conversion at a time
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            arb_q <= ARB_IDLE;
            owner_q <= 1'b0;
            slot_q <= 4'h0;
            startConv_q <= 1'b0;
            muxChannel <= 4'h0;
        end
        else
        begin
            startConv_q <= 1'b0;
            case (arb_q)
                ARB_IDLE:
                    if (coreOn && seqActive_q != 2'h0)
                    begin
                        arb_q <= ARB_CONVERT;
                        owner_q <= grant;
                        slot_q <= ptr_q[grant];
                        startConv_q <= 1'b1;
                        // [R5] channel group per sequencer
                        muxChannel <= ctrl_q.cascade ? slotSel_q[ptr_q[grant]]
                            : {grant, slotSel_q[ptr_q[grant]][2:0]};
                    end
                ARB_CONVERT:
                    if (convResult.valid)
                        arb_q <= ARB_IDLE;
                default:
                    arb_q <= ARB_IDLE;
            endcase
        end
    end

    // [R12] timing from divider enables on the one clock
    aas_conv_timer convTimer (
        .clock(clock),
        .reset(reset),
        .start(startConv_q),
        .convPrescale(ctrl_q.convPrescale),
        .acqPrescale(ctrl_q.acqPrescale),
        .levelMv(levelB_q),
        .sampleHold(sampleHold),
        .busy(convBusy),
        .result(convResult)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencers
    always_comb
    begin
        for (int s = 0; s < 2; s++)
            eosEvent[s] = convResult.valid && owner_q == s[0] && slot_q == lastSlot[s];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            seqActive_q <= 2'h0;
            ptr_q[0] <= 4'h0;
            ptr_q[1] <= SEQ2_FIRST_SLOT;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (convResult.valid && owner_q == s[0])
                begin
                    // [R19] advance, wrap after last slot
                    if (eosEvent[s])
                    begin
                        ptr_q[s] <= firstSlot[s];
                        seqActive_q[s] <= 1'b0;
                    end
                    else
                    begin
                        ptr_q[s] <= slot_q + 4'h1;
                        // [R9] pause after one slot
                        if (ctrl_q.startStop)
                            seqActive_q[s] <= 1'b0;
                    end
                end
                // a trigger in the completing cycle is not lost
                if (trigReq[s] && !(seqActive_q[s] && !(convResult.valid
                    && owner_q == s[0])))
                begin
                    seqActive_q[s] <= 1'b1;
                    if (!ctrl_q.startStop)
                        ptr_q[s] <= firstSlot[s];
                end
            end
        end
    end

    // [R6] store result by slot
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
                resultMem_q[i] <= 12'h000;
        end
        else if (convResult.valid)
            resultMem_q[slot_q] <= convResult.code;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts; a set in the clearing cycle wins
    always_comb
    begin
        for (int s = 0; s < 2; s++)
            // [R8] every or every second end
            intSet[s] = eosEvent[s] && (!ctrl_q.everyOther || evenEos_q[s]);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            intStat_q <= INT_RESET;
            evenEos_q <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            evenEos_q <= evenEos_q ^ eosEvent;
            if (wbWrite && regRun && wbAdr == REG_INT_STAT && wbSel[0])
                intStat_q <= (intStat_q & ~wbDatWr[1:0]) | intSet;
            else
                intStat_q <= intStat_q | intSet;
            irq <= |(intStat_q & intMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power and register clock gate
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            regClockEnable <= 1'b1;
            analogCoreEnable <= 1'b0;
        end
        else
        begin
            regClockEnable <= ctrl_q.convClockEnable;
            analogCoreEnable <= coreOn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux and single-wait-state acknowledge
    always_comb
    begin
        rdData = 32'h0000_0000;
        if (wbAdr[7:6] == REGION_SLOT)
            rdData[3:0] = slotSel_q[wbAdr[5:2]];
        else if (wbAdr[7:6] == REGION_RESULT)
            rdData[11:0] = resultMem_q[wbAdr[5:2]];
        else
            case (wbAdr)
                REG_CTRL: rdData[11:0] = ctrl_q;
                REG_MAXCONV: rdData[6:0] = maxConv_q;
                REG_STATUS: rdData[11:0] = {ptr_q[1], ptr_q[0], seqActive_q,
                    convBusy, coreOn};
                REG_INT_STAT: rdData[1:0] = intStat_q;
                REG_INT_MASK: rdData[1:0] = intMask_q;
                default: rdData = 32'h0000_0000;
            endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wbAck <= 1'b0;
            wbDatRd <= 32'h0000_0000;
        end
        else
        begin
            wbAck <= busReq;
            wbDatRd <= busReq ? rdData : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (@(posedge clock) disable iff (reset)
        wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("bus acknowledge not a single cycle pulse");
    a_reset_power_state: assert property (@(posedge clock) // [R13]
        reset |=> regClockEnable && !analogCoreEnable)
        else $error("reset did not keep register clock on and core off");
    a_reg_clock_stop: assert property (@(posedge clock) disable iff (reset) // [R14]
        !ctrl_q.convClockEnable ##1 !ctrl_q.convClockEnable |-> !regClockEnable)
        else $error("register clock runs without enable");
    a_halt_core_off: assert property (@(posedge clock) disable iff (reset) // [R16]
        syncB_q[3] |=> !analogCoreEnable)
        else $error("core powered during halt");
    a_serial_convert: assert property (@(posedge clock) disable iff (reset) // [R4]
        startConv_q |-> !$past(convBusy) && arb_q == ARB_CONVERT)
        else $error("conversion started while converter busy");
    a_dual_channel_group: assert property (@(posedge clock) disable iff (reset) // [R5]
        startConv_q && !ctrl_q.cascade |-> muxChannel[3] == owner_q)
        else $error("sequencer left its channel group");
    a_result_stored: assert property (@(posedge clock) disable iff (reset) // [R6]
        convResult.valid |=> resultMem_q[$past(slot_q)] == $past(convResult.code))
        else $error("result not stored in its slot");
    a_trigger_arms: assert property (@(posedge clock) disable iff (reset) // [R7]
        trigReq[0] |=> seqActive_q[0])
        else $error("trigger did not arm sequencer");
    a_every_eos_irq: assert property (@(posedge clock) disable iff (reset) // [R8]
        eosEvent[0] && !ctrl_q.everyOther |=> intStat_q[0])
        else $error("end of sequence did not set status");
    a_slot_advance: assert property (@(posedge clock) disable iff (reset) // [R19]
        convResult.valid && !owner_q && slot_q != lastSlot[0] && !trigReq[0]
        |=> ptr_q[0] == $past(slot_q) + 4'h1)
        else $error("slot pointer did not advance");
    a_irq_follows: assert property (@(posedge clock) disable iff (reset)
        |(intStat_q & intMask_q) |=> irq)
        else $error("unmasked status without interrupt");

    c_cascade_done: cover property (@(posedge clock) disable iff (reset)
        eosEvent[0] && ctrl_q.cascade && maxConv_q[3]);
    c_dual_both: cover property (@(posedge clock) disable iff (reset)
        seqActive_q == 2'h3);
    c_start_stop_pause: cover property (@(posedge clock) disable iff (reset)
        convResult.valid && ctrl_q.startStop && !eosEvent[0] && !owner_q);
    c_every_other: cover property (@(posedge clock) disable iff (reset)
        eosEvent[1] && ctrl_q.everyOther && !intSet[1]);
endmodule

/* File: verification/aas_analog_src.sv */
/*
 * Analog source model: sixteen channel levels in millivolts behind the mux.
 * Assumes the bench sets a common offset while the converter is idle.
 */
`timescale 1ns/100ps
module aas_analog_src
(
    input wire logic [3:0] muxChannel,
    input wire logic [5:0] offsetMv,
    output logic signed [15:0] analogLevelMv
);
    // slope spans below 0 V to above full scale, so both clamps are reached
    assign analogLevelMv = $signed({12'h000, muxChannel}) * 16'sd230 - 16'sd300
        + $signed({10'h000, offsetMv});
endmodule

/* File: verification/aas_top_tb_top.sv */
/*
 * Self-checking bench: register bus, start sources, codes, result slots, irq.
 * Assumes the design package and the analog source model compile first.
 */
`timescale 1ns/100ps
module aas_top_tb_top
    import aas_pkg::*;
;
    logic clock, reset, wbCyc, wbStb, wbWe, wbAck, haltMode, sampleHold;
    logic analogCoreEnable, regClockEnable, irq;
    logic [7:0] wbAdr;
    logic [3:0] wbSel, muxChannel;
    logic [31:0] wbDatWr, wbDatRd, rd;
    logic [2:0] trg;
    logic [5:0] offsetMv;
    logic signed [15:0] analogLevelMv;
    logic [15:0] rnd;
    int err_total, checked;
    aas_top u_dut (.clock(clock), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd),
        .wbAck(wbAck), .firstPwmConvTrigger(trg[0]), .secondPwmConvTrigger(trg[1]),
        .externalTriggerPin(trg[2]), .haltMode(haltMode), .analogLevelMv(analogLevelMv),
        .muxChannel(muxChannel), .sampleHold(sampleHold), .analogCoreEnable(analogCoreEnable),
        .regClockEnable(regClockEnable), .irq(irq));
    aas_analog_src u_src (.muxChannel(muxChannel), .offsetMv(offsetMv),
        .analogLevelMv(analogLevelMv));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [11:0] expCode(input logic [3:0] ch);
        int mv;
        mv = int'(ch) * 230 - 300 + int'(offsetMv);
        if (mv <= 0) return 12'h000;
        if (mv >= FULL_SCALE_MV) return CODE_MAX;
        return 12'(mv * CODE_SPAN / FULL_SCALE_MV);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one request per call; release at the ack edge leaves one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatWr} <= {2'b11, w, a, 4'hF, d};
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wbAck !== 1'b1 && n < 50);
        rd = wbDatRd;
        {wbCyc, wbStb} <= 2'b00;
        if (wbAck !== 1'b1)
        begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd & 32'h0000_0FFF);
    endtask
    task automatic waitIrq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge clock);
            n++;
        end
        if (irq !== 1'b1)
        begin
            err_total++;
            stop_test();
        end
    endtask
    // sources 0..2 are pins, 3 is the software start
    task automatic fire(input int i);
        if (i == 3)
            wb(1'b1, REG_START, 32'h0000_0001);
        else
        begin
            @(posedge clock);
            trg[i] <= 1'b1;
            repeat (4) @(posedge clock);
            trg[i] <= 1'b0;
        end
    endtask
    // one trigger, then a fixed window that counts acquisition cycles
    task automatic fireCount(input int i, output int hold);
        hold = 0;
        fire(i);
        repeat (80)
        begin
            @(posedge clock);
            hold += int'(sampleHold);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [3:0] ch [0:3];
        int hold;
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatWr} = '0;
        {reset, trg, haltMode, offsetMv} = {1'b1, 3'h0, 1'b0, 6'h00};
        rnd = 16'h09CD;
        err_total = 0;
        checked = 0;
        repeat (10) @(posedge clock);
        chk("regclk in reset", 32'h1, 32'(regClockEnable));
        chk("core in reset", 32'h0, 32'(analogCoreEnable));
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        chk("regclk idle", 32'h0, 32'(regClockEnable));
        rdChk("ctrl reset", REG_CTRL, 32'h0000_0000);
        rdChk("unmapped", 8'hFC, 32'h0000_0000);
        wb(1'b1, REG_CTRL, 32'h0000_0103);
        // settling wait kept short to bound run time
        repeat (200) @(posedge clock);
        chk("regclk on", 32'h1, 32'(regClockEnable));
        chk("core on", 32'h1, 32'(analogCoreEnable));
        for (int s = 0; s < 4; s++)
        begin
            rnd = lfsr(rnd);
            offsetMv <= rnd[5:0];
            for (int k = 0; k < 4; k++)
            begin
                rnd = lfsr(rnd);
                // pass 1 forces both clamp ends
                ch[k] = (k == 3) ? ch[0] : (s == 1) ? {4{k[0]}} : rnd[3:0];
                wb(1'b1, 8'h40 + 8'(4 * k), 32'(ch[k]));
            end
            wb(1'b1, REG_MAXCONV, 32'h0000_0003);
            wb(1'b1, REG_INT_MASK, 32'(s != 2));
            fire(s);
            if (s == 2)
            begin
                repeat (300) @(posedge clock);
                chk("irq masked", 32'h0, 32'(irq));
                wb(1'b1, REG_INT_MASK, 32'h0000_0001);
            end
            waitIrq();
            for (int k = 0; k < 4; k++)
                rdChk("result", 8'h80 + 8'(4 * k), 32'(expCode(ch[k])));
            rdChk("int stat", REG_INT_STAT, 32'h0000_0001);
            wb(1'b1, REG_INT_STAT, 32'h0000_0001);
            repeat (3) @(posedge clock);
            chk("irq cleared", 32'h0, 32'(irq));
        end
        wb(1'b1, REG_CTRL, 32'h0000_0101);
        rnd = lfsr(rnd);
        ch[0] = rnd[3:0];
        wb(1'b1, 8'h60, 32'(ch[0]));
        wb(1'b1, REG_MAXCONV, 32'h0000_0000);
        wb(1'b1, REG_INT_MASK, 32'h0000_0002);
        fire(1);
        waitIrq();
        chk("mux seq2", 32'({1'b1, ch[0][2:0]}), 32'(muxChannel));
        rdChk("result 8", 8'hA0, 32'(expCode({1'b1, ch[0][2:0]})));
        rdChk("int stat seq2", REG_INT_STAT, 32'h0000_0002);
        // dual, every other end, start/stop, conv prescale 1, two slots on seq1
        wb(1'b1, REG_CTRL, 32'h0000_001D);
        wb(1'b1, REG_MAXCONV, 32'h0000_0001);
        wb(1'b1, REG_INT_MASK, 32'h0000_0001);
        haltMode <= 1'b1;
        repeat (6) @(posedge clock);
        chk("core halted", 32'h0, 32'(analogCoreEnable));
        haltMode <= 1'b0;
        // four ends of sequence so far on seq1, so only the sixth raises irq
        for (int t = 0; t < 4; t++)
        begin
            fireCount(0, hold);
            chk("hold cycles", 32'(ACQ_UNIT_CYCLES), 32'(hold));
            chk("every other", 32'(t == 3), 32'(irq));
        end
        stop_test();
    end
endmodule
